//--- hdl/direct_control_write_decode.sv
// Direct-control write decode: turns a write-direct instruction into a
// static data byte or pulsed command lines toward another element.
// Assumes the instruction pipe presents one-cycle execute strobes.
`timescale 1ns/1ns
`default_nettype none
module direct_control_write_decode (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          isIoElement,
    input  wire logic                          supervisorState,
    input  wire logic                          writeDirectInstr,
    input  wire logic [7:0]                    immediateByteField,
    input  wire logic [7:0]                    operandByte,
    input  wire logic                          selfListenEnable,
    input  wire logic                          readDirectInstr,
    input  wire logic                          holdIn,
    output var  logic                          instrDone,
    output var  logic                          privilegeCheck,
    output var  logic                          specCheck,
    output var  logic                          invalidOpCheck,
    output var  logic                          machineCheck,
    output var  logic                          readDone,
    output var  logic [7:0]                    directOutData,
    output var  logic                          holdOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] extStartOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] peLogoutOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] ioLogoutOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] extStopOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] ioStartOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] ioStopOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] ioIntrOut,
    output var  logic [dctl_pkg::NUM_TARGETS-1:0] dataStrobeOut,
    output var  logic                          selfStart,
    output var  logic                          selfStop,
    output var  logic                          selfLogout,
    output var  logic                          selfData
);
    import dctl_pkg::*;

    // ******************************************************
    // Instruction field decode
    // ******************************************************
    wire logic [3:0] opCode   = immediateByteField[OP_MSB:OP_LSB];
    wire logic [3:0] targets  = immediateByteField[SEL_MSB:SEL_LSB];
    wire logic       opValid  = ~opCode[3];
    wire logic       oneHot   = (targets != 4'h0) && ((targets & (targets - 4'h1)) == 4'h0);
    wire logic       multiSel = ~oneHot && (targets != 4'h0);
    // I/O elements have no fourth target
    wire logic       ioTarget = (opCode == OP_IO_LOGOUT) || (opCode >= OP_IO_START);
    wire logic       badTgt   = ioTarget && targets[SEL_LSB];
    // I/O element may only raise its one interrupt command (code 1000)
    wire logic       ioAllowed = isIoElement && (opCode == OP_ELEM_INTR);
    wire logic       privOk   = isIoElement || supervisorState;
    wire logic       isCmd    = opValid && (opCode != OP_DATA);
    wire logic       specFail = (isCmd && (multiSel || badTgt)) ||
                                (isIoElement && !ioAllowed);
    wire logic       accept   = writeDirectInstr && privOk && !specFail &&
                                (opValid || ioAllowed);
    wire logic       toSelf   = selfListenEnable && !isIoElement;

    // ******************************************************
    // Command state machine: one pulse of fixed length per command
    // ******************************************************
    state_type   state_ff;
    state_type   nxt_state;
    logic [3:0]  opHeld_ff;
    logic [3:0]  tgtHeld_ff;
    logic [7:0]  pulseCnt_ff;
    logic        ioSelfHeld_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (pulseCnt_ff == 8'(PULSE_CYCLES - 1)) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    wire logic pulsing = (state_ff == ST_PULSE);
    // One line per target for the held operation
    wire logic [3:0] lineMask = pulsing ? tgtHeld_ff : 4'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff      <= ST_IDLE;
            opHeld_ff     <= 4'h0;
            tgtHeld_ff    <= 4'h0;
            pulseCnt_ff   <= 8'h00;
            ioSelfHeld_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && accept) begin
                opHeld_ff     <= opCode;
                tgtHeld_ff    <= ioAllowed ? 4'h8 : targets;
                ioSelfHeld_ff <= toSelf;
            end
            pulseCnt_ff <= pulsing ? pulseCnt_ff + 8'h01 : 8'h00;
        end
    end

    // ******************************************************
    // Command lines toward the selected element
    // ******************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            extStartOut   <= 4'h0;
            peLogoutOut   <= 4'h0;
            ioLogoutOut   <= 4'h0;
            extStopOut    <= 4'h0;
            ioStartOut    <= 4'h0;
            ioStopOut     <= 4'h0;
            ioIntrOut     <= 4'h0;
            dataStrobeOut <= 4'h0;
            selfStart     <= 1'b0;
            selfStop      <= 1'b0;
            selfLogout    <= 1'b0;
            selfData      <= 1'b0;
        end else begin
            extStartOut   <= (opHeld_ff == OP_EXT_START) ? lineMask : 4'h0;
            peLogoutOut   <= (opHeld_ff == OP_PE_LOGOUT) ? lineMask : 4'h0;
            ioLogoutOut   <= (opHeld_ff == OP_IO_LOGOUT) ? lineMask : 4'h0;
            extStopOut    <= (opHeld_ff == OP_EXT_STOP)  ? lineMask : 4'h0;
            ioStartOut    <= (opHeld_ff == OP_IO_START)  ? lineMask : 4'h0;
            ioStopOut     <= (opHeld_ff == OP_IO_STOP)   ? lineMask : 4'h0;
            ioIntrOut     <= (opHeld_ff == OP_IO_INTR || opHeld_ff == OP_ELEM_INTR) ?
                             lineMask : 4'h0;
            dataStrobeOut <= (opHeld_ff == OP_DATA)      ? lineMask : 4'h0;
            selfStart     <= pulsing && ioSelfHeld_ff && opHeld_ff == OP_EXT_START;
            selfStop      <= pulsing && ioSelfHeld_ff && opHeld_ff == OP_EXT_STOP;
            selfLogout    <= pulsing && ioSelfHeld_ff && opHeld_ff == OP_PE_LOGOUT;
            selfData      <= pulsing && ioSelfHeld_ff && opHeld_ff == OP_DATA;
        end
    end

    // ******************************************************
    // Static data byte and completion status
    // ******************************************************
    wire logic dataLoad = accept && state_ff == ST_IDLE && opCode == OP_DATA && !isIoElement;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            directOutData  <= DATA_RESET;
            holdOut        <= 1'b0;
            instrDone      <= 1'b0;
            privilegeCheck <= 1'b0;
            specCheck      <= 1'b0;
            invalidOpCheck <= 1'b0;
        end else begin
            if (dataLoad) begin
                directOutData <= operandByte;
            end
            holdOut        <= dataLoad;
            instrDone      <= (state_ff == ST_DONE) ||
                              (writeDirectInstr && state_ff == ST_IDLE && !accept);
            privilegeCheck <= writeDirectInstr && state_ff == ST_IDLE && !privOk;
            specCheck      <= writeDirectInstr && state_ff == ST_IDLE && privOk
                              && specFail;
            invalidOpCheck <= writeDirectInstr && state_ff == ST_IDLE && privOk
                              && !specFail && !opValid && !ioAllowed;
        end
    end

    // ******************************************************
    // Read-direct side: wait for hold-in to drop, bounded time
    // ******************************************************
    logic        holdInSync;
    logic        reading_ff;
    logic [15:0] holdCnt_ff;

    sync3 holdSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (holdIn),
        .syncOut (holdInSync)
    );

    wire logic readStart = readDirectInstr && supervisorState && !isIoElement;
    wire logic timedOut  = holdCnt_ff >= 16'(HOLD_CYCLES);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reading_ff   <= 1'b0;
            holdCnt_ff   <= 16'h0000;
            readDone     <= 1'b0;
            machineCheck <= 1'b0;
        end else begin
            readDone     <= reading_ff && !holdInSync;
            machineCheck <= reading_ff && holdInSync && timedOut;
            if (reading_ff) begin
                if (!holdInSync || timedOut) begin
                    reading_ff <= 1'b0;
                end
                holdCnt_ff <= holdCnt_ff + 16'h0001;
            end else begin
                reading_ff <= readStart;
                holdCnt_ff <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

//--- inc/dctl_pkg.sv
// Constants for the direct-control write decode block.
// Assumes one system clock and a synchronous active-high reset.
// Overview of operation
// - Processing element direct ops need supervisor state
// - I/O element write allowed in problem state
// - Bits 8-11 select operation; bit 8 invalid
// - Bits 12-15 one-hot target; bit 15 element 4
// - Own start, stop, PE logout and data commands looped back when self-listen enabled
// - Data byte held static until next write
// - Output lines cause action at receiver
// - Multiple targets on command end with specification check
package dctl_pkg;

    // ******************************************************
    // Field positions within the immediate byte field
    // ******************************************************
    localparam int OP_MSB  = 7;   // Instruction bit 8
    localparam int OP_LSB  = 4;   // Instruction bit 11
    localparam int SEL_MSB = 3;   // Instruction bit 12
    localparam int SEL_LSB = 0;   // Instruction bit 15
    localparam int NUM_TARGETS = 4;

    // ******************************************************
    // Operation codes
    // ******************************************************
    localparam logic [3:0] OP_DATA      = 4'h0;
    localparam logic [3:0] OP_EXT_START = 4'h1;
    localparam logic [3:0] OP_PE_LOGOUT = 4'h2;
    localparam logic [3:0] OP_IO_LOGOUT = 4'h3;
    localparam logic [3:0] OP_EXT_STOP  = 4'h4;
    localparam logic [3:0] OP_IO_START  = 4'h5;
    localparam logic [3:0] OP_IO_STOP   = 4'h6;
    localparam logic [3:0] OP_IO_INTR   = 4'h7;
    localparam logic [3:0] OP_ELEM_INTR = 4'h8;   // I/O element's own interrupt command

    // ******************************************************
    // Reset values and timing
    // ******************************************************
    localparam logic [7:0] DATA_RESET   = 8'h00;
    localparam int         CLK_MHZ      = 250;
    localparam int         PULSE_CYCLES = 4;   // Length of command line pulse
    localparam int         HOLD_NS      = 4000;
    localparam int         HOLD_CYCLES  = HOLD_NS * CLK_MHZ / 1000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PULSE = 3'b010,
        ST_DONE  = 3'b100
    } state_type;

endpackage

//--- hdl/sync3.sv
// Three-stage synchroniser for one level from outside the clock domain.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module sync3 (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic asyncIn,
    output var  logic syncOut
);
    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;

    // ******************************************************
    // Shift chain; output changes when stages two and three agree
    // ******************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
            syncOut   <= 1'b0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            if (stage2_ff == stage3_ff) begin
                syncOut <= stage3_ff;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/dctl_sva.sv
// Port checker for the direct-control write decode block.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module dctl_sva (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       isIoElement,
    input wire logic       supervisorState,
    input wire logic       writeDirectInstr,
    input wire logic [7:0] immediateByteField,
    input wire logic       selfListenEnable,
    input wire logic       privilegeCheck,
    input wire logic       specCheck,
    input wire logic       invalidOpCheck,
    input wire logic       machineCheck,
    input wire logic [7:0] directOutData,
    input wire logic [3:0] extStartOut,
    input wire logic [3:0] peLogoutOut,
    input wire logic [3:0] ioLogoutOut,
    input wire logic [3:0] extStopOut,
    input wire logic [3:0] ioStartOut,
    input wire logic [3:0] ioStopOut,
    input wire logic [3:0] ioIntrOut,
    input wire logic [3:0] dataStrobeOut,
    input wire logic       selfStart
);
    import dctl_pkg::*;
    // All command lines, the operation field and a supervisor write
    wire logic [31:0] lines = {extStartOut, peLogoutOut, ioLogoutOut, extStopOut,
                               ioStartOut, ioStopOut, ioIntrOut, dataStrobeOut};
    wire logic [3:0]  op    = immediateByteField[7:4];
    wire logic        ceWr  = writeDirectInstr && supervisorState && !isIoElement;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_priv_refuse: assert property (
        writeDirectInstr && !supervisorState && !isIoElement |-> ##1 privilegeCheck)
        else $error("problem state write not refused");
    chk_op_invalid: assert property (
        ceWr && op[3] |-> ##1 invalidOpCheck ##0 (lines == 32'h0 && $stable(directOutData))[*6])
        else $error("invalid operation had an effect");
    chk_one_target: assert property ($onehot0(lines))
        else $error("more than one command line high");
    chk_pulse_len: assert property (
        $rose(|lines) |-> (|lines)[*4] ##1 !(|lines))
        else $error("command line pulse length wrong");
    chk_multi_spec: assert property (
        ceWr && op inside {[1:6]} && $countones(immediateByteField[3:0]) > 1 |-> ##1 specCheck)
        else $error("multiple targets not refused");
    chk_data_hold: assert property (
        $changed(directOutData) |-> $past(writeDirectInstr) || $past(writeDirectInstr, 2))
        else $error("data byte moved without a write");
    chk_self_loop: assert property (
        ceWr && op == OP_EXT_START && $onehot(immediateByteField[3:0]) && selfListenEnable
        |-> ##[1:3] selfStart) else $error("own start not looped back");
    chk_io_intr: assert property (
        writeDirectInstr && isIoElement && op == 4'h8 |-> ##[1:3] ioIntrOut[3])
        else $error("element interrupt line not raised");
    cov_data: cover property (ceWr && op == OP_DATA);
    cov_mcheck: cover property (machineCheck);
    cov_self: cover property (selfStart);
endmodule
bind direct_control_write_decode dctl_sva chk (.clk_sys, .rst, .isIoElement, .supervisorState,
    .writeDirectInstr, .immediateByteField, .selfListenEnable, .privilegeCheck, .specCheck,
    .invalidOpCheck, .machineCheck, .directOutData, .extStartOut, .peLogoutOut, .ioLogoutOut,
    .extStopOut, .ioStartOut, .ioStopOut, .ioIntrOut, .dataStrobeOut, .selfStart);
`default_nettype wire

//--- tb/peer_model.sv
// Receiving element facing target 1: gates commands and drives hold-in.
// Assumes command lines are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module peer_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       cmdLine,
    input  wire logic       dataLine,
    input  wire logic       senderEnable,
    input  wire logic       peFieldBit,
    input  wire logic       holdOut,
    input  wire logic       stall,
    input  wire logic       readDone,
    input  wire logic [7:0] directOutData,
    output var  logic       holdIn,
    output var  logic [7:0] actCount,
    output var  logic [7:0] capturedByte
);
    // Byte is not static while it moves or while a stall is ordered
    assign holdIn = holdOut | stall;
    // Commands count in the low nibble, data transfers in the high one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            actCount <= 8'h00;
        end else if ($rose(cmdLine) && senderEnable) begin
            actCount <= actCount + 8'h01;
        end else if ($rose(dataLine) && peFieldBit) begin
            actCount <= actCount + 8'h10;
        end
        if (readDone) begin
            capturedByte <= directOutData;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the direct-control write decode block with one peer.
// Assumes package, design, checker and peer are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dctl_pkg::*;
    logic clk_sys, rst, isIoElement, supervisorState, writeDirectInstr, selfListenEnable;
    logic readDirectInstr, holdIn, stall, senderEnable, peFieldBit, instrDone, holdOut;
    logic privilegeCheck, specCheck, invalidOpCheck, machineCheck, readDone;
    logic selfStart, selfStop, selfLogout, selfData;
    logic [7:0] immediateByteField, operandByte, directOutData, actCount, capturedByte, base;
    logic [3:0] extStartOut, peLogoutOut, ioLogoutOut, extStopOut, seenSelf;
    logic [3:0] ioStartOut, ioStopOut, ioIntrOut, dataStrobeOut;
    logic [31:0] seenLines;
    logic [3:0]  seenChk;
    int          hiCnt, err_count = 0, total_checks = 0;
    wire logic [31:0] allLines = {extStartOut, peLogoutOut, ioLogoutOut, extStopOut,
                                  ioStartOut, ioStopOut, ioIntrOut, dataStrobeOut};
    direct_control_write_decode DUT (.clk_sys, .rst, .isIoElement, .supervisorState,
        .writeDirectInstr, .immediateByteField, .operandByte, .selfListenEnable,
        .readDirectInstr, .holdIn, .instrDone, .privilegeCheck, .specCheck, .invalidOpCheck,
        .machineCheck, .readDone, .directOutData, .holdOut, .extStartOut, .peLogoutOut,
        .ioLogoutOut, .extStopOut, .ioStartOut, .ioStopOut, .ioIntrOut, .dataStrobeOut,
        .selfStart, .selfStop, .selfLogout, .selfData);
    peer_model peer (.clk_sys, .rst, .cmdLine(extStartOut[3] | extStopOut[3] | peLogoutOut[3]),
        .dataLine(dataStrobeOut[3]), .senderEnable, .peFieldBit, .holdOut, .stall, .readDone,
        .directOutData, .holdIn, .actCount, .capturedByte);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One write, gathering the command, self-loop, hold and check outputs until completion
    task automatic do_wr(input logic [7:0] f, input logic [7:0] d);
        int n;
        immediateByteField = f;
        operandByte = d;
        writeDirectInstr = 1'b1;
        @(posedge clk_sys) #1 writeDirectInstr = 1'b0;
        {seenLines, seenSelf, seenChk, hiCnt} = '0;
        for (n = 0; n < 20; n++) begin
            seenLines |= allLines;
            seenSelf |= {selfStart, selfStop, selfLogout, selfData};
            seenChk |= {holdOut, privilegeCheck, specCheck, invalidOpCheck};
            hiCnt += int'(allLines != 32'h0);
            if (instrDone === 1'b1) break;
            @(posedge clk_sys) #1;
        end
        if (n == 20) begin
            err_count++;
            give_verdict();
        end
        @(posedge clk_sys) #1;
    endtask
    task automatic t_cmds();
        for (int op = 0; op < 8; op++)
            for (int t = 0; t < 4; t++)
                if (t != 0 || op inside {[0:2], 4}) begin
                    do_wr({op[3:0], 4'h1 << t}, 8'h00);
                    check(seenLines, 32'(4'h1 << t) << (op == 0 ? 0 : 32 - op * 4));
                    check(32'(hiCnt), 32'(PULSE_CYCLES));
                end
        $display("t_cmds done");
    endtask
    task automatic t_data();
        base = actCount;
        do_wr(8'h08, 8'hA5);
        check(32'(directOutData), 32'hA5);
        check(32'(actCount), 32'(base + 8'h10));
        check(32'(seenChk), 32'h8);
        do_wr(8'h18, 8'h3C);
        check(32'(directOutData), 32'hA5);
        check(32'(actCount), 32'(base + 8'h11));
        senderEnable = 1'b0;
        do_wr(8'h48, 8'h00);
        check(32'(actCount), 32'(base + 8'h11));
        senderEnable = 1'b1;
        peFieldBit = 1'b0;
        do_wr(8'h08, 8'h5A);
        check(32'(actCount), 32'(base + 8'h11));
        check(32'(directOutData), 32'h5A);
        peFieldBit = 1'b1;
        do_wr(8'h98, 8'h77);
        check(seenLines, 32'h0);
        check(32'(seenChk), 32'h1);
        check(32'(directOutData), 32'h5A);
        $display("t_data done");
    endtask
    task automatic t_checks();
        do_wr(8'h1C, 8'h00);
        check(seenLines, 32'h0);
        check(32'(seenChk), 32'h2);
        supervisorState = 1'b0;
        do_wr(8'h18, 8'h00);
        check(32'(seenChk), 32'h4);
        isIoElement = 1'b1;
        do_wr(8'h80, 8'h00);
        check(seenLines, 32'h80);
        do_wr(8'h18, 8'h00);
        check(32'(seenChk), 32'h2);
        isIoElement = 1'b0;
        supervisorState = 1'b1;
        do_wr(8'h31, 8'h00);
        check(32'(seenChk), 32'h2);
        $display("t_checks done");
    endtask
    task automatic t_self();
        logic [7:0] ops [4] = '{8'h14, 8'h44, 8'h24, 8'h04};
        selfListenEnable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            do_wr(ops[k], 8'hA5);
            check(32'(seenSelf), 32'h8 >> k);
        end
        selfListenEnable = 1'b0;
        $display("t_self done");
    endtask
    // Plain read, then one with hold-in stuck high
    task automatic t_read();
        int n;
        logic [1:0] got;
        for (int k = 0; k < 2; k++) begin
            stall = k[0];
            // Let hold-in settle through the synchroniser first
            repeat (5) @(posedge clk_sys) #1;
            readDirectInstr = 1'b1;
            @(posedge clk_sys) #1 readDirectInstr = 1'b0;
            for (n = 0; n < 1200; n++) begin
                got = {machineCheck, readDone};
                if (got !== 2'b00) break;
                @(posedge clk_sys) #1;
            end
            check(32'(got), k == 0 ? 32'h1 : 32'h2);
            check(32'(n > 900), 32'(k));
            @(posedge clk_sys) #1;
        end
        check(32'(capturedByte), 32'hA5);
        stall = 1'b0;
        $display("t_read done");
    endtask
    initial begin
        {isIoElement, writeDirectInstr, selfListenEnable, readDirectInstr, stall} = '0;
        {immediateByteField, operandByte} = '0;
        {supervisorState, senderEnable, peFieldBit, rst} = '1;
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_cmds();
        t_data();
        t_checks();
        t_self();
        t_read();
        give_verdict();
    end
endmodule
`default_nettype wire
